/* lpm_pkg.sv */
// package for the low-power mode sequencer: register map, fields, states, timing.
// assumes a single 100 MHz bus clock and a plain strobe register port.
package lpm_pkg;

   // register offsets (byte-wide registers on the plain port)
   localparam logic [7:0] LPM_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] LPM_STATUS_ADDR = 8'h01;
   localparam logic [7:0] LPM_RTI_ADDR    = 8'h02;

   // control register fields
   localparam int LPM_CTRL_STOP_ENABLE_BIT_BIT  = 0;
   localparam int LPM_CTRL_DEEP_BIT   = 1;
   localparam int LPM_CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT   = 2;
   localparam int LPM_CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT  = 3;
   localparam int LPM_CTRL_DBGEN_BIT  = 4;
   localparam int LPM_CTRL_ACK_BIT    = 7;
   localparam logic [4:0] LPM_CTRL_RESET = 5'h00;

   // status register fields
   localparam int LPM_STAT_WAKEF_BIT  = 0;
   localparam int LPM_STAT_LATCH_BIT  = 1;
   localparam int LPM_STAT_MODE_LSB   = 4;

   // periodic wake-up
   localparam logic [2:0] LPM_RTI_RESET   = 3'h0;
   localparam logic [2:0] LPM_RTI_OFF     = 3'h0;
   localparam int LPM_CLK_MHZ             = 100;
   localparam int LPM_LPO_PERIOD_US       = 1000;
   localparam int LPM_LPO_CYCLES          = LPM_LPO_PERIOD_US * LPM_CLK_MHZ;

   localparam int LPM_PIN_W = 8;

   typedef enum logic [2:0] {
      LPM_RUN   = 3'b000,
      LPM_WAIT  = 3'b001,
      LPM_LIGHT = 3'b010,
      LPM_DEEP  = 3'b011,
      LPM_BKGD  = 3'b100
   } lpm_mode_type;

endpackage

/* lpm_ctrl.sv */
// low-power mode sequencer: wait, light stop and deep stop with pin latch.
// assumes the cpu reports instructions as one-cycle pulses and obeys the
// run/clock enables; wake sources arrive synchronous to clk_i.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps

module lpm_ctrl
   import lpm_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   input  wire logic                 por_i,
   // register port
   input  wire logic [7:0]           addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [7:0]           rdata_o,
   // cpu instruction events
   input  wire logic                 wait_instr_i,
   input  wire logic                 stop_instr_i,
   input  wire logic                 irq_pending_i,
   output logic                      cpu_clk_en_o,
   output logic                      clear_imask_o,
   output logic                      illegal_reset_o,
   output logic                      fetch_reset_vec_o,
   output logic                      fetch_irq_vec_o,
   output logic                      sys_reset_o,
   // wake sources
   input  wire logic                 reset_pin_n_i,
   input  wire logic                 ext_int_n_i,
   input  wire logic                 lvd_int_i,
   input  wire logic                 conv_int_i,
   input  wire logic                 kbi_int_i,
   input  wire logic                 sci_int_i,
   input  wire logic                 ext_int_i,
   // debug command
   input  wire logic                 bkgd_cmd_i,
   input  wire logic                 status_cmd_i,
   input  wire logic                 other_cmd_i,
   output logic                      cmd_accept_o,
   output logic                      cmd_err_stopwait_o,
   output logic                      bkgd_active_o,
   // power and clock controls
   output logic                      periph_clk_en_o,
   output logic                      dbg_clk_en_o,
   output logic                      osc_en_o,
   output logic                      clkgen_standby_o,
   output logic                      reg_standby_o,
   output logic                      logic_power_on_o,
   output logic                      lpo_en_o,
   // pins
   input  wire logic [LPM_PIN_W-1:0] port_out_i,
   input  wire logic [LPM_PIN_W-1:0] port_oe_i,
   input  wire logic [LPM_PIN_W-1:0] periph_out_i,
   input  wire logic [LPM_PIN_W-1:0] periph_oe_i,
   input  wire logic [LPM_PIN_W-1:0] periph_en_i,
   output logic      [LPM_PIN_W-1:0] pin_out_o,
   output logic      [LPM_PIN_W-1:0] pin_oe_o
);

   typedef struct packed {
      lpm_mode_type          mode;
      logic [4:0]            ctrl;
      logic [2:0]            rti_sel;
      logic                  wake_flag;
      logic                  latched;
      logic [LPM_PIN_W-1:0]  lat_out;
      logic [LPM_PIN_W-1:0]  lat_oe;
      logic [20:0]           lpo_cnt;
      logic                  rti_tick;
      logic                  light_stop_sel;
      logic                  dbg_in_stop;
      logic [7:0]            rdata;
      logic                  illegal;
      logic                  rst_vec;
      logic                  irq_vec;
      logic                  sysrst;
   } lpm_state_type;

   lpm_state_type s_q;
   lpm_state_type s_d;

   logic in_stop;
   logic low_power;
   logic wr_ctrl;
   logic light_wake;
   logic deep_wake;

   function automatic logic [LPM_PIN_W-1:0] pin_mux(input logic [LPM_PIN_W-1:0] en,
                                                     input logic [LPM_PIN_W-1:0] p,
                                                     input logic [LPM_PIN_W-1:0] g);
      pin_mux = (en & p) | (~en & g);
   endfunction

   assign in_stop   = (s_q.mode == LPM_LIGHT) || (s_q.mode == LPM_DEEP);
   assign low_power = in_stop || (s_q.mode == LPM_WAIT);
   assign wr_ctrl   = wr_i && (addr_i == LPM_CTRL_ADDR);

   // periodic wake counts only with a non-zero period select
   assign light_wake = ~reset_pin_n_i | s_q.rti_tick | lvd_int_i | conv_int_i
                     | ext_int_i | kbi_int_i | sci_int_i;
   // external pin forced active low regardless of its earlier setup
   assign deep_wake  = ~reset_pin_n_i | ~ext_int_n_i | s_q.rti_tick;

   always_comb begin
      s_d          = s_q;
      s_d.illegal  = 1'b0;
      s_d.rst_vec  = 1'b0;
      s_d.irq_vec  = 1'b0;
      s_d.sysrst   = 1'b0;
      s_d.rti_tick = 1'b0;
      s_d.rdata    = 8'h00;

      // free-running low-power oscillator model, off when period select is zero
      if (s_q.rti_sel == LPM_RTI_OFF) begin
         s_d.lpo_cnt = '0;
      // longest period setting needs 21 bits of count
      end else if (s_q.lpo_cnt >= 21'((LPM_LPO_CYCLES << s_q.rti_sel) >> 3) - 21'd1) begin
         s_d.lpo_cnt  = '0;
         s_d.rti_tick = 1'b1;
      end else begin
         s_d.lpo_cnt = s_q.lpo_cnt + 21'd1;
      end

      if (wr_i) begin
         case (addr_i)
            LPM_CTRL_ADDR: begin
               s_d.ctrl = wdata_i[4:0];
            end
            LPM_RTI_ADDR: begin
               s_d.rti_sel = wdata_i[2:0];
            end
            default: begin
            end
         endcase
      end
      // acknowledge releases latch and flag; software restores ports first
      if (wr_ctrl && wdata_i[LPM_CTRL_ACK_BIT]) begin
         s_d.latched   = 1'b0;
         s_d.wake_flag = 1'b0;
      end
      if (rd_i) begin
         case (addr_i)
            LPM_CTRL_ADDR:   s_d.rdata = {3'h0, s_q.ctrl};
            LPM_STATUS_ADDR: s_d.rdata = {1'b0, s_q.mode, 2'h0, s_q.latched, s_q.wake_flag};
            LPM_RTI_ADDR:    s_d.rdata = {5'h0, s_q.rti_sel};
            default:         s_d.rdata = 8'h00;
         endcase
      end

      case (s_q.mode)
         LPM_RUN: begin
            if (wait_instr_i) begin
               s_d.mode = LPM_WAIT;
            end else if (stop_instr_i) begin
               if (!s_q.ctrl[LPM_CTRL_STOP_ENABLE_BIT_BIT]) begin
                  s_d.illegal = 1'b1;
                  s_d.sysrst  = 1'b1;
                  s_d.rst_vec = 1'b1;
               end else begin
                  s_d.dbg_in_stop = s_q.ctrl[LPM_CTRL_DBGEN_BIT];
                  s_d.light_stop_sel = s_q.ctrl[LPM_CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT] && s_q.ctrl[LPM_CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT];
                  if (s_q.ctrl[LPM_CTRL_DEEP_BIT]
                      && !(s_q.ctrl[LPM_CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT] && s_q.ctrl[LPM_CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT])
                      && !s_q.ctrl[LPM_CTRL_DBGEN_BIT]) begin
                     s_d.mode    = LPM_DEEP;
                     s_d.latched = 1'b1;
                     s_d.lat_out = pin_out_o;
                     s_d.lat_oe  = pin_oe_o;
                  end else begin
                     s_d.mode = LPM_LIGHT;
                  end
               end
            end
         end
         LPM_WAIT: begin
            if (bkgd_cmd_i) begin
               s_d.mode = LPM_BKGD;
            end else if (irq_pending_i) begin
               s_d.mode    = LPM_RUN;
               s_d.irq_vec = 1'b1;
            end
         end
         LPM_LIGHT: begin
            if (bkgd_cmd_i && s_q.dbg_in_stop) begin
               s_d.mode = LPM_BKGD;
            end else if (!reset_pin_n_i) begin
               s_d.mode    = LPM_RUN;
               s_d.sysrst  = 1'b1;
               s_d.rst_vec = 1'b1;
            end else if (light_wake) begin
               s_d.mode    = LPM_RUN;
               s_d.irq_vec = 1'b1;
            end
         end
         LPM_DEEP: begin
            if (deep_wake) begin
               // behaves as power-on except latches and ram survive and the wake flag is set
               s_d.mode      = LPM_RUN;
               s_d.ctrl      = LPM_CTRL_RESET;
               s_d.rti_sel   = LPM_RTI_RESET;
               s_d.sysrst    = 1'b1;
               s_d.rst_vec   = 1'b1;
               s_d.wake_flag = 1'b1;
            end
         end
         LPM_BKGD: begin
            if (other_cmd_i) begin
               s_d.mode = LPM_RUN;
            end
         end
         default: begin
            s_d.mode = LPM_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s_q         <= '0;
         s_q.mode    <= LPM_RUN;
         s_q.ctrl    <= LPM_CTRL_RESET;
         s_q.rti_sel <= LPM_RTI_RESET;
      end else if (por_i) begin
         // a true power-on leaves the wake flag clear
         s_q         <= '0;
         s_q.mode    <= LPM_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o           = s_q.rdata;
   assign illegal_reset_o   = s_q.illegal;
   assign fetch_reset_vec_o = s_q.rst_vec;
   assign fetch_irq_vec_o   = s_q.irq_vec;
   assign sys_reset_o       = s_q.sysrst;
   assign bkgd_active_o     = (s_q.mode == LPM_BKGD);

   assign cpu_clk_en_o  = (s_q.mode == LPM_RUN);
   assign clear_imask_o = (s_q.mode == LPM_RUN) && wait_instr_i;

   // in low-power modes only background and status commands are honoured
   assign cmd_accept_o       = !low_power || bkgd_cmd_i || status_cmd_i;
   assign cmd_err_stopwait_o = low_power && status_cmd_i;

   assign periph_clk_en_o  = !in_stop;
   assign dbg_clk_en_o     = !in_stop || s_q.dbg_in_stop;
   assign osc_en_o         = !in_stop || s_q.dbg_in_stop;
   assign clkgen_standby_o = in_stop && !s_q.dbg_in_stop;
   assign reg_standby_o    = in_stop && !s_q.dbg_in_stop && !s_q.light_stop_sel;
   assign logic_power_on_o = (s_q.mode != LPM_DEEP);
   assign lpo_en_o         = (s_q.rti_sel != LPM_RTI_OFF);

   // latched pins win; otherwise port control drives unenabled peripherals
   assign pin_out_o = s_q.latched ? s_q.lat_out
                    : pin_mux(periph_en_i, periph_out_i, port_out_i);
   assign pin_oe_o  = s_q.latched ? s_q.lat_oe
                    : pin_mux(periph_en_i, periph_oe_i, port_oe_i);

endmodule

/* lpm_ctrl_sva.sv */
// port-level assertions for the low-power mode sequencer.
// assumes binding into lpm_ctrl; a single clock domain on clk_i.
`timescale 1ns/1ps
module lpm_ctrl_sva
   import lpm_pkg::*;
(
   // clock and reset
   input wire logic                 clk_i,
   input wire logic                 rstn_i,
   // watched inputs
   input wire logic                 wait_instr_i,
   input wire logic                 stop_instr_i,
   input wire logic                 status_cmd_i,
   input wire logic                 other_cmd_i,
   input wire logic                 ext_int_n_i,
   input wire logic                 kbi_int_i,
   // watched outputs
   input wire logic                 cpu_clk_en_o,
   input wire logic                 clear_imask_o,
   input wire logic                 illegal_reset_o,
   input wire logic                 sys_reset_o,
   input wire logic                 fetch_reset_vec_o,
   input wire logic                 fetch_irq_vec_o,
   input wire logic                 cmd_accept_o,
   input wire logic                 cmd_err_stopwait_o,
   input wire logic                 bkgd_active_o,
   input wire logic                 periph_clk_en_o,
   input wire logic                 osc_en_o,
   input wire logic                 reg_standby_o,
   input wire logic                 logic_power_on_o,
   input wire logic [LPM_PIN_W-1:0] pin_out_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   AST_WAIT_MASK: assert property (cpu_clk_en_o && wait_instr_i |-> clear_imask_o ##1 !cpu_clk_en_o)
      else $error("wait did not clear mask and halt cpu");
   AST_ILLEGAL: assert property (illegal_reset_o |-> $past(stop_instr_i) && fetch_reset_vec_o)
      else $error("illegal reset without stop");
   AST_STOP_CLK: assert property (cpu_clk_en_o && stop_instr_i |=> illegal_reset_o || !periph_clk_en_o)
      else $error("stop left peripheral clocks on");
   AST_CMD_ERR: assert property (!cpu_clk_en_o && !bkgd_active_o && status_cmd_i |-> cmd_err_stopwait_o)
      else $error("status command without stop or wait error");
   AST_CMD_REFUSE: assert property (!cpu_clk_en_o && !bkgd_active_o && other_cmd_i |-> !cmd_accept_o)
      else $error("command accepted in stop or wait");
   AST_PERIPH: assert property (!osc_en_o |-> !periph_clk_en_o)
      else $error("peripheral clock on with oscillator off");
   AST_DEEP_PWR: assert property (!logic_power_on_o |-> reg_standby_o && !osc_en_o)
      else $error("deep stop not in standby");
   AST_PIN_HOLD: assert property (!logic_power_on_o && $past(!logic_power_on_o) |-> $stable(pin_out_o))
      else $error("pins moved during deep stop");
   AST_DEEP_WAKE: assert property (!logic_power_on_o && !ext_int_n_i |=> sys_reset_o && fetch_reset_vec_o && !fetch_irq_vec_o)
      else $error("deep stop wake not a reset");
   AST_LIGHT_IRQ: assert property (logic_power_on_o && !osc_en_o && !cpu_clk_en_o && kbi_int_i |=> fetch_irq_vec_o && !sys_reset_o)
      else $error("light stop wake without vector");
endmodule

bind lpm_ctrl lpm_ctrl_sva u_lpm_ctrl_sva (.*);

/* lpm_cpu_model.sv */
// cpu-side model: holds an interrupt request until its vector is fetched.
// assumes raise pulses from the bench on clk_i.
`timescale 1ns/1ps
module lpm_cpu_model (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // request and answer
   input  wire logic raise_i,
   input  wire logic fetch_irq_vec_i,
   output logic      irq_pending_o
);
   // level request, dropped on reset or once the vector is taken
   always_ff @(posedge clk_i) begin
      if (!rstn_i || fetch_irq_vec_i) begin
         irq_pending_o <= 1'b0;
      end else if (raise_i) begin
         irq_pending_o <= 1'b1;
      end
   end
endmodule

/* lpm_ctrl_tb.sv */
// testbench for lpm_ctrl: register tasks, mode walks, pin latch, wake paths.
// assumes the cpu model answers interrupt requests; one 100 MHz clock.
`timescale 1ns/1ps
module lpm_ctrl_tb
   import lpm_pkg::*;
;
   logic clk_i, rstn_i, por_i, wr_i, rd_i, wait_instr_i, stop_instr_i, irq_pending_i;
   logic cpu_clk_en_o, clear_imask_o, illegal_reset_o, fetch_reset_vec_o, fetch_irq_vec_o;
   logic sys_reset_o, reset_pin_n_i, ext_int_n_i, lvd_int_i, conv_int_i, kbi_int_i;
   logic sci_int_i, ext_int_i, bkgd_cmd_i, status_cmd_i, other_cmd_i, cmd_accept_o;
   logic cmd_err_stopwait_o, bkgd_active_o, periph_clk_en_o, dbg_clk_en_o, osc_en_o;
   logic clkgen_standby_o, reg_standby_o, logic_power_on_o, lpo_en_o, raise;
   logic [7:0] addr_i, wdata_i, rdata_o;
   logic [LPM_PIN_W-1:0] port_out_i, port_oe_i, periph_out_i, periph_oe_i, periph_en_i;
   logic [LPM_PIN_W-1:0] pin_out_o, pin_oe_o;
   int n_fail, cmp_count;
   logic [7:0] ctl [5] = '{8'h01, 8'h03, 8'h0F, 8'h07, 8'h13};
   logic [2:0] md [5] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h4};

   lpm_ctrl u_lpm_ctrl (.*);
   lpm_cpu_model u_lpm_cpu_model (.clk_i(clk_i), .rstn_i(rstn_i), .raise_i(raise),
      .fetch_irq_vec_i(fetch_irq_vec_o), .irq_pending_o(irq_pending_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task stop_test();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task ck(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 ck(rdata_o, e);
   endtask

   // k: 0 wait, 1 stop, 2 background, 3 status, 4 other command, 5 irq raise
   task pl(input int k);
      @(posedge clk_i);
      {wait_instr_i, stop_instr_i, bkgd_cmd_i, status_cmd_i, other_cmd_i, raise} <= 6'h20 >> k;
      @(posedge clk_i);
      {wait_instr_i, stop_instr_i, bkgd_cmd_i, status_cmd_i, other_cmd_i, raise} <= 6'h00;
   endtask

   // bounded wait for a one-cycle pulse; running out ends the run
   task automatic wt(ref logic s, input int n);
      int i;
      #1;
      for (i = 0; i < n && s !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      ck({7'h00, s}, 8'h01);
      if (s !== 1'b1) stop_test();
   endtask

   initial begin
      {rstn_i, por_i, wr_i, rd_i, addr_i, wdata_i} = '0;
      {wait_instr_i, stop_instr_i, bkgd_cmd_i, status_cmd_i, other_cmd_i, raise} = '0;
      {reset_pin_n_i, ext_int_n_i, lvd_int_i, conv_int_i, kbi_int_i, sci_int_i, ext_int_i} = 7'h60;
      {port_out_i, port_oe_i, periph_out_i} = {8'hA5, 8'hFF, 8'h5A};
      {periph_oe_i, periph_en_i} = '0;
      n_fail = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(LPM_CTRL_ADDR, 8'h00);
      rd(LPM_STATUS_ADDR, 8'h00);
      rd(LPM_RTI_ADDR, 8'h00);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h00);
      ck(pin_out_o, 8'hA5);
      pl(0);
      rd(LPM_STATUS_ADDR, 8'h10);
      pl(5);
      wt(fetch_irq_vec_o, 10);
      rd(LPM_STATUS_ADDR, 8'h00);
      pl(0);
      pl(3);
      pl(2);
      rd(LPM_STATUS_ADDR, 8'h40);
      pl(4);
      rd(LPM_STATUS_ADDR, 8'h00);
      pl(1);
      wt(illegal_reset_o, 3);
      for (int j = 0; j < 5; j++) begin
         wr(LPM_CTRL_ADDR, ctl[j]);
         pl(1);
         @(posedge clk_i);
         #1 ck({7'h00, reg_standby_o}, {7'h00, ~((ctl[j][2] & ctl[j][3]) | ctl[j][4])});
         ck({7'h00, dbg_clk_en_o}, {7'h00, ctl[j][4]});
         ck({7'h00, clkgen_standby_o}, {7'h00, ~ctl[j][4]});
         pl(3);
         pl(2);
         rd(LPM_STATUS_ADDR, {1'b0, md[j], 4'h0} | (md[j] == 3'h3 ? 8'h02 : 8'h00));
         if (md[j] == 3'h3) begin
            @(posedge clk_i);
            {port_out_i, ext_int_n_i} <= {8'h3C, 1'b0};
            wt(fetch_reset_vec_o, 5);
            @(posedge clk_i);
            ext_int_n_i <= 1'b1;
            ck(pin_out_o, 8'hA5);
            ck(pin_oe_o, 8'hFF);
            rd(LPM_STATUS_ADDR, 8'h03);
            rd(LPM_CTRL_ADDR, 8'h00);
            wr(LPM_CTRL_ADDR, 8'h80);
            rd(LPM_STATUS_ADDR, 8'h00);
            ck(pin_out_o, 8'h3C);
            @(posedge clk_i);
            port_out_i <= 8'hA5;
         end else if (md[j] == 3'h4) begin
            pl(4);
            rd(LPM_STATUS_ADDR, 8'h00);
         end else begin
            @(posedge clk_i);
            kbi_int_i <= 1'b1;
            wt(fetch_irq_vec_o, 5);
            @(posedge clk_i);
            kbi_int_i <= 1'b0;
            rd(LPM_CTRL_ADDR, ctl[j]);
         end
      end
      wr(LPM_RTI_ADDR, 8'h01);
      #1 ck({7'h00, lpo_en_o}, 8'h01);
      wr(LPM_CTRL_ADDR, 8'h01);
      pl(1);
      wt(fetch_irq_vec_o, 30000);
      wr(LPM_RTI_ADDR, 8'h00);
      #1 ck({7'h00, lpo_en_o}, 8'h00);
      stop_test();
   end
endmodule
